// ---- test/ppfs_checker.sv ----
`timescale 1ns/1ns
module ppfs_checker (
	input wire        ref_clk,
	input wire        rst,
	input wire [3:0]  regAddr,
	input wire [15:0] regWrData,
	input wire        regWrite,
	input wire        regRead,
	input wire [15:0] regRdData,
	input wire [31:0] pinOutEn,
	input wire [31:0] pullUpEn,
	input wire [31:0] altSelect,
	input wire        debugMode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_rd_idle; !regRead |=> regRdData == 16'h0000; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero while idle");
	property p_wr_rd;
		regWrite && regAddr == 4'h0 ##1 regRead && regAddr == 4'h0
		|=> regRdData == $past(regWrData, 2);
	endproperty
	a_wr_rd: assert property (p_wr_rd)
		else $error("port h select read back wrong");
	property p_dbg_hold;
		!rst && !$past(rst) && !$past(rst, 2) |-> $stable(debugMode);
	endproperty
	a_dbg_hold: assert property (p_dbg_hold)
		else $error("debug mode moved after reset");
	property p_oe_pu; (pinOutEn & pullUpEn) == 32'h0000_0000; endproperty
	a_oe_pu: assert property (p_oe_pu)
		else $error("driven pin also pulled up");
	property p_l_noport;
		(pinOutEn[31:24] & ~altSelect[31:24]) == 8'h00;
	endproperty
	a_l_noport: assert property (p_l_noport)
		else $error("port l driven as port output");
	property p_h_noport; (pinOutEn[6:0] & ~altSelect[6:0]) == 7'h00; endproperty
	a_h_noport: assert property (p_h_noport)
		else $error("port h low pin driven as port output");
	property p_j_res; (altSelect & 32'h0000_3200) == 32'h0000_0000; endproperty
	a_j_res: assert property (p_j_res)
		else $error("reserved port j pin on peripheral");
	property p_alt_pu; (altSelect & pullUpEn) == 32'h0000_0000; endproperty
	a_alt_pu: assert property (p_alt_pu)
		else $error("peripheral pin has pull-up");
endmodule

// ---- test/ppfs_pin_model.sv ----
`timescale 1ns/1ns
module ppfs_pin_model (
	input  wire [31:0] pinOut,
	input  wire [31:0] pinOutEn,
	input  wire [31:0] pullUpEn,
	input  wire [31:0] extLevel,
	output wire [31:0] pinLevel
);
	// driven pins follow chip, pulled pins float high
	assign pinLevel = (pinOutEn & pinOut)
		| (~pinOutEn & pullUpEn) | (~pinOutEn & ~pullUpEn & extLevel);
endmodule

// ---- test/test_port_pin_function_select.sv ----
`timescale 1ns/1ns
module test_port_pin_function_select;
	reg         ref_clk = 1'b0;
	reg         rst = 1'b1;
	reg         manualRst = 1'b0;
	reg         debugModeStrap = 1'b1;
	reg  [3:0]  regAddr = 4'h0;
	reg  [15:0] regWrData = 16'h0000;
	reg         regWrite = 1'b0;
	reg         regRead = 1'b0;
	reg  [31:0] extLevel = 32'h0000_0000;
	reg  [31:0] altDrive = 32'h0000_0000;
	reg  [31:0] altDriveEn = 32'h0000_0000;
	wire [15:0] regRdData;
	wire [31:0] pinOut, pinOutEn, pullUpEn, altSelect, pinLevel, altIn;
	wire        debugMode;
	integer     failures = 0;
	integer     num_checks = 0;
	integer     i;

	always #20 ref_clk = ~ref_clk;

	ppfs_pin_function_select i_dut (.ref_clk(ref_clk), .rst(rst),
		.manualRst(manualRst), .debugModeStrap(debugModeStrap),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData),
		.portHIn(pinLevel[7:0]), .portJIn(pinLevel[15:8]),
		.portKIn(pinLevel[23:16]), .portLIn(pinLevel[31:24]),
		.altOut(altDrive), .altOutEn(altDriveEn),
		.pinOut(pinOut), .pinOutEn(pinOutEn), .pullUpEn(pullUpEn),
		.altSelect(altSelect), .altIn(altIn), .debugMode(debugMode));

	ppfs_pin_model i_pins (.pinOut(pinOut), .pinOutEn(pinOutEn),
		.pullUpEn(pullUpEn), .extLevel(extLevel), .pinLevel(pinLevel));

	task chk(input string nm, input [15:0] seen, input [15:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask

	task wr(input [3:0] a, input [15:0] d);
		begin
			regAddr <= a;
			regWrData <= d;
			regWrite <= 1'b1;
			@(posedge ref_clk);
			regWrite <= 1'b0;
		end
	endtask

	task rd(input [3:0] a, input [15:0] e);
		begin
			regAddr <= a;
			regRead <= 1'b1;
			@(posedge ref_clk);
			regRead <= 1'b0;
			#1 chk("regRdData", regRdData, e);
			@(posedge ref_clk);
		end
	endtask

	task report_and_stop;
		begin
			$display("checks %0d failures %0d", num_checks, failures);
			if (failures == 0 && num_checks > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask

	// strap moves right after release; latched mode must not
	task t_reset(input s);
		begin
			debugModeStrap <= s;
			rst <= 1'b1;
			repeat (3) @(posedge ref_clk);
			rst <= 1'b0;
			debugModeStrap <= ~s;
			@(posedge ref_clk);
			rd(4'h0, s ? 16'hAAAA : 16'h8AAA);
			for (i = 1; i < 4; i = i + 1)
				rd(i[3:0], 16'h0000);
			rd(4'hC, {15'h0000, s});
			chk("debugMode", {15'h0000, debugMode}, {15'h0000, s});
			chk("altH", {8'h00, altSelect[7:0]},
				s ? 16'h0000 : 16'h0040);
			chk("pullH", {8'h00, pullUpEn[7:0]},
				s ? 16'h00FF : 16'h00BF);
			chk("altJ", {8'h00, altSelect[15:8]}, 16'h00CD);
			chk("altKL", altSelect[31:16], 16'hFFFF);
		end
	endtask

	task t_rw;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				wr(i[3:0], 16'hC35A ^ i[15:0]);
				rd(i[3:0], 16'hC35A ^ i[15:0]);
			end
			wr(4'hF, 16'hFFFF);
			rd(4'hF, 16'h0000);
			wr(4'h5, 16'hFFA5);
			rd(4'h5, 16'h00A5);
			wr(4'h1, 16'h1234);
			manualRst <= 1'b1;
			@(posedge ref_clk);
			manualRst <= 1'b0;
			rd(4'h1, 16'h1234);
			rd(4'h5, 16'h0000);
		end
	endtask

	// peripheral drives K and reads L; H reads back as plain input
	task t_alt;
		begin
			altDrive <= 32'h005A_0000;
			altDriveEn <= 32'h000F_0000;
			extLevel <= 32'hC300_003C;
			wr(4'h0, 16'hFFFF);
			@(posedge ref_clk);
			wr(4'h2, 16'h0000);
			@(posedge ref_clk);
			wr(4'h3, 16'h0000);
			repeat (5) @(posedge ref_clk);
			#1 chk("altK", {pinOut[23:16], pinOutEn[23:16]},
				16'h5A0F);
			chk("altIn", altIn[31:16], 16'hC30A);
			chk("pullH", {8'h00, pullUpEn[7:0]}, 16'h0000);
			@(posedge ref_clk);
			rd(4'h8, 16'h003C);
		end
	endtask

	// expect is {peripheral, driven, pulled up} for one pin
	task t_code(input [1:0] p, input [2:0] n, input [1:0] c,
		input [2:0] e);
		integer b;
		begin
			b = p * 8 + n;
			wr({2'h0, p}, {14'h0000, c} << (2 * n));
			repeat (2) @(posedge ref_clk);
			#1 chk("mode", {13'h0000, altSelect[b], pinOutEn[b],
				pullUpEn[b]}, {13'h0000, e});
			if (e[1])
				chk("pinOut", {15'h0000, pinOut[b]}, 16'h0001);
			@(posedge ref_clk);
		end
	endtask

	initial begin
		t_reset(1'b1);
		t_rw;
		for (i = 4; i < 8; i = i + 1) begin
			wr(i[3:0], 16'h00FF);
			@(posedge ref_clk);
		end
		t_code(2'h0, 3'h7, 2'h0, 3'h4);
		t_code(2'h0, 3'h7, 2'h1, 3'h2);
		t_code(2'h0, 3'h7, 2'h3, 3'h0);
		t_code(2'h0, 3'h7, 2'h2, 3'h1);
		repeat (3) @(posedge ref_clk);
		rd(4'h8, 16'h0080);
		t_code(2'h0, 3'h6, 2'h1, 3'h0);
		t_code(2'h0, 3'h0, 2'h1, 3'h0);
		t_code(2'h1, 3'h1, 2'h0, 3'h0);
		t_code(2'h1, 3'h0, 2'h0, 3'h4);
		t_code(2'h1, 3'h5, 2'h1, 3'h2);
		t_code(2'h2, 3'h3, 2'h1, 3'h2);
		t_code(2'h2, 3'h3, 2'h3, 3'h0);
		t_code(2'h3, 3'h7, 2'h1, 3'h0);
		t_code(2'h3, 3'h0, 2'h2, 3'h1);
		t_alt;
		t_reset(1'b0);
		report_and_stop;
	end

	initial begin
		#(40 * 5000);
		failures = failures + 1;
		report_and_stop;
	end
endmodule

bind ppfs_pin_function_select ppfs_checker i_chk (.ref_clk(ref_clk),
	.rst(rst), .regAddr(regAddr), .regWrData(regWrData),
	.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
	.pinOutEn(pinOutEn), .pullUpEn(pullUpEn), .altSelect(altSelect),
	.debugMode(debugMode));

// ---- verilog/ppfs_defs.vh ----
`ifndef PPFS_DEFS_VH
`define PPFS_DEFS_VH

// register indices on the plain register port
`define PPFS_ADDR_W        4
`define PPFS_IDX_H         4'h0
`define PPFS_IDX_J         4'h1
`define PPFS_IDX_K         4'h2
`define PPFS_IDX_L         4'h3
`define PPFS_IDX_DATA_H    4'h4
`define PPFS_IDX_DATA_J    4'h5
`define PPFS_IDX_DATA_K    4'h6
`define PPFS_IDX_DATA_L    4'h7
`define PPFS_IDX_PIN_H     4'h8
`define PPFS_IDX_PIN_J     4'h9
`define PPFS_IDX_PIN_K     4'hA
`define PPFS_IDX_PIN_L     4'hB
`define PPFS_IDX_STRAP     4'hC

// power-on values
`define PPFS_RST_H_STRAP1  16'hAAAA
`define PPFS_RST_H_STRAP0  16'h8AAA
`define PPFS_RST_JKL       16'h0000
`define PPFS_RST_DATA      8'h00

// pin function codes
`define PPFS_CODE_OTHER    2'b00
`define PPFS_CODE_OUT      2'b01
`define PPFS_CODE_IN_PU    2'b10
`define PPFS_CODE_IN_NOPU  2'b11

// per-port capability masks, one bit per pin
`define PPFS_H_OUT_MASK    8'h80
`define PPFS_H_OTHER_MASK  8'hFF
`define PPFS_J_OUT_MASK    8'hFF
`define PPFS_J_OTHER_MASK  8'hCD
`define PPFS_K_OUT_MASK    8'hFF
`define PPFS_K_OTHER_MASK  8'hFF
`define PPFS_L_OUT_MASK    8'h00
`define PPFS_L_OTHER_MASK  8'hFF

`define PPFS_READ_ZERO     16'h0000

`endif

// ---- verilog/ppfs_pin_function_select.v ----
`timescale 1ns/1ns
`include "ppfs_defs.vh"
// How it works
// R1: four 16-bit registers, two bits per pin
// R2: port H powers up by strap value
// R3: ports J, K, L power up zero
// R4: only power-on reset clears these registers
// R5: H7: other, output, input pullup, input
// R6: H6: other, reserved, input pullup, input
// R7: H0-H5: other, reserved, input pullup, input
// R8: J: other or reserved, output, inputs
// R9: K: other, output, input pullup, input
// R10: L: other, reserved, input pullup, input
// R11: software keeps L at reset when converting
// R12: strap sampled in reset, then port input
// R13: output drives data; inputs float, readable
module ppfs_pin_function_select (
	input  wire                    ref_clk,
	input  wire                    rst,
	input  wire                    manualRst,
	input  wire                    debugModeStrap,
	input  wire [`PPFS_ADDR_W-1:0] regAddr,
	input  wire [15:0]             regWrData,
	input  wire                    regWrite,
	input  wire                    regRead,
	output reg  [15:0]             regRdData,
	input  wire [7:0]              portHIn,
	input  wire [7:0]              portJIn,
	input  wire [7:0]              portKIn,
	input  wire [7:0]              portLIn,
	input  wire [31:0]             altOut,
	input  wire [31:0]             altOutEn,
	output reg  [31:0]             pinOut,
	output reg  [31:0]             pinOutEn,
	output reg  [31:0]             pullUpEn,
	output reg  [31:0]             altSelect,
	output reg  [31:0]             altIn,
	output reg                     debugMode
);
	reg  [15:0] selH_q;
	reg  [15:0] selJ_q;
	reg  [15:0] selK_q;
	reg  [15:0] selL_q;
	reg  [7:0]  dataH_q;
	reg  [7:0]  dataJ_q;
	reg  [7:0]  dataK_q;
	reg  [7:0]  dataL_q;
	reg         strapLatch_q;
	reg  [15:0] rdData_d;
	wire [31:0] pinSync;
	wire [31:0] decOut;
	wire [31:0] decOutEn;
	wire [31:0] decPull;
	wire [31:0] decAlt;
	wire [31:0] decInMode;
	wire        strapSync;
	wire        wrH;
	wire        wrJ;
	wire        wrK;
	wire        wrL;
	wire        wrDataH;
	wire        wrDataJ;
	wire        wrDataK;
	wire        wrDataL;

	wire [7:0]  pinRdH;
	wire [7:0]  pinRdJ;
	wire [7:0]  pinRdK;
	wire [7:0]  pinRdL;

	ppfs_sync2 #(
		.WIDTH (33)
	) u_sync (
		.ref_clk (ref_clk),
		.async   ({debugModeStrap, portLIn, portKIn, portJIn, portHIn}),
		.synced  ({strapSync, pinSync})
	);

	// strap caught while reset is held; pin is a port input after release
	always @(posedge ref_clk) begin
		if (rst) begin
			strapLatch_q <= strapSync; // see R12
		end
	end

	assign wrH = regWrite && (regAddr == `PPFS_IDX_H);
	assign wrJ = regWrite && (regAddr == `PPFS_IDX_J);
	assign wrK = regWrite && (regAddr == `PPFS_IDX_K);
	assign wrL = regWrite && (regAddr == `PPFS_IDX_L);
	assign wrDataH = regWrite && (regAddr == `PPFS_IDX_DATA_H);
	assign wrDataJ = regWrite && (regAddr == `PPFS_IDX_DATA_J);
	assign wrDataK = regWrite && (regAddr == `PPFS_IDX_DATA_K);
	assign wrDataL = regWrite && (regAddr == `PPFS_IDX_DATA_L);

	// power-on reset only; manualRst never reaches the selects
	always @(posedge ref_clk) begin
		if (rst) begin // see R4
			// see R2
			selH_q <= strapSync ? `PPFS_RST_H_STRAP1 : `PPFS_RST_H_STRAP0;
		end else if (wrH) begin
			selH_q <= regWrData; // see R1
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin // see R4
			selJ_q <= `PPFS_RST_JKL; // see R3
		end else if (wrJ) begin
			selJ_q <= regWrData; // see R1
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin // see R4
			selK_q <= `PPFS_RST_JKL; // see R3
		end else if (wrK) begin
			selK_q <= regWrData; // see R1
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin // see R4
			selL_q <= `PPFS_RST_JKL; // see R3
		end else if (wrL) begin
			// software leaves this at reset while converting; see R11
			selL_q <= regWrData; // see R1
		end
	end

	// port data; cleared by either reset, unlike the selects
	always @(posedge ref_clk) begin
		if (rst || manualRst) begin
			dataH_q <= `PPFS_RST_DATA;
		end else if (wrDataH) begin
			dataH_q <= regWrData[7:0];
		end
	end

	always @(posedge ref_clk) begin
		if (rst || manualRst) begin
			dataJ_q <= `PPFS_RST_DATA;
		end else if (wrDataJ) begin
			dataJ_q <= regWrData[7:0];
		end
	end

	always @(posedge ref_clk) begin
		if (rst || manualRst) begin
			dataK_q <= `PPFS_RST_DATA;
		end else if (wrDataK) begin
			dataK_q <= regWrData[7:0];
		end
	end

	always @(posedge ref_clk) begin
		if (rst || manualRst) begin
			dataL_q <= `PPFS_RST_DATA;
		end else if (wrDataL) begin
			dataL_q <= regWrData[7:0];
		end
	end

	// see R5 see R6 see R7
	ppfs_port_decode #(
		.OUT_MASK   (`PPFS_H_OUT_MASK),
		.OTHER_MASK (`PPFS_H_OTHER_MASK)
	) u_dec_h (
		.sel       (selH_q),
		.portData  (dataH_q),
		.altOut    (altOut[7:0]),
		.altOutEn  (altOutEn[7:0]),
		.pinOut    (decOut[7:0]),
		.pinOutEn  (decOutEn[7:0]),
		.pullUpEn  (decPull[7:0]),
		.altSelect (decAlt[7:0]),
		.inputMode (decInMode[7:0])
	);

	// see R8
	ppfs_port_decode #(
		.OUT_MASK   (`PPFS_J_OUT_MASK),
		.OTHER_MASK (`PPFS_J_OTHER_MASK)
	) u_dec_j (
		.sel       (selJ_q),
		.portData  (dataJ_q),
		.altOut    (altOut[15:8]),
		.altOutEn  (altOutEn[15:8]),
		.pinOut    (decOut[15:8]),
		.pinOutEn  (decOutEn[15:8]),
		.pullUpEn  (decPull[15:8]),
		.altSelect (decAlt[15:8]),
		.inputMode (decInMode[15:8])
	);

	// see R9
	ppfs_port_decode #(
		.OUT_MASK   (`PPFS_K_OUT_MASK),
		.OTHER_MASK (`PPFS_K_OTHER_MASK)
	) u_dec_k (
		.sel       (selK_q),
		.portData  (dataK_q),
		.altOut    (altOut[23:16]),
		.altOutEn  (altOutEn[23:16]),
		.pinOut    (decOut[23:16]),
		.pinOutEn  (decOutEn[23:16]),
		.pullUpEn  (decPull[23:16]),
		.altSelect (decAlt[23:16]),
		.inputMode (decInMode[23:16])
	);

	// see R10
	ppfs_port_decode #(
		.OUT_MASK   (`PPFS_L_OUT_MASK),
		.OTHER_MASK (`PPFS_L_OTHER_MASK)
	) u_dec_l (
		.sel       (selL_q),
		.portData  (dataL_q),
		.altOut    (altOut[31:24]),
		.altOutEn  (altOutEn[31:24]),
		.pinOut    (decOut[31:24]),
		.pinOutEn  (decOutEn[31:24]),
		.pullUpEn  (decPull[31:24]),
		.altSelect (decAlt[31:24]),
		.inputMode (decInMode[31:24])
	);

	// pin levels shown to software: input-mode pins only; see R13
	assign pinRdH = pinSync[7:0] & decInMode[7:0];
	assign pinRdJ = pinSync[15:8] & decInMode[15:8];
	assign pinRdK = pinSync[23:16] & decInMode[23:16];
	assign pinRdL = pinSync[31:24] & decInMode[31:24];

	// registered pin controls, one flop per output; see R13
	always @(posedge ref_clk) begin
		if (rst) begin
			pinOut <= 32'h0000_0000;
		end else begin
			pinOut <= decOut;
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			pinOutEn <= 32'h0000_0000;
		end else begin
			pinOutEn <= decOutEn;
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			pullUpEn <= 32'h0000_0000;
		end else begin
			pullUpEn <= decPull;
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			altSelect <= 32'h0000_0000;
		end else begin
			altSelect <= decAlt;
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			altIn <= 32'h0000_0000;
		end else begin
			altIn <= pinSync & decAlt;
		end
	end

	// latched strap stands until the next power-on reset; see R12
	always @(posedge ref_clk) begin
		if (rst) begin
			debugMode <= 1'b0;
		end else begin
			debugMode <= strapLatch_q;
		end
	end

	always @* begin
		rdData_d = `PPFS_READ_ZERO;
		case (regAddr)
		`PPFS_IDX_H: begin
			rdData_d = selH_q;
		end
		`PPFS_IDX_J: begin
			rdData_d = selJ_q;
		end
		`PPFS_IDX_K: begin
			rdData_d = selK_q;
		end
		`PPFS_IDX_L: begin
			rdData_d = selL_q;
		end
		`PPFS_IDX_DATA_H: begin
			rdData_d = {8'h00, dataH_q};
		end
		`PPFS_IDX_DATA_J: begin
			rdData_d = {8'h00, dataJ_q};
		end
		`PPFS_IDX_DATA_K: begin
			rdData_d = {8'h00, dataK_q};
		end
		`PPFS_IDX_DATA_L: begin
			rdData_d = {8'h00, dataL_q};
		end
		`PPFS_IDX_PIN_H: begin
			rdData_d = {8'h00, pinRdH};
		end
		`PPFS_IDX_PIN_J: begin
			rdData_d = {8'h00, pinRdJ};
		end
		`PPFS_IDX_PIN_K: begin
			rdData_d = {8'h00, pinRdK};
		end
		`PPFS_IDX_PIN_L: begin
			rdData_d = {8'h00, pinRdL};
		end
		`PPFS_IDX_STRAP: begin
			rdData_d = {15'h0000, strapLatch_q};
		end
		default: begin
			rdData_d = `PPFS_READ_ZERO;
		end
		endcase
	end

	// read data stands only in the cycle after the strobe
	always @(posedge ref_clk) begin
		if (rst) begin
			regRdData <= `PPFS_READ_ZERO;
		end else if (regRead) begin
			regRdData <= rdData_d;
		end else begin
			regRdData <= `PPFS_READ_ZERO;
		end
	end
endmodule

// ---- verilog/ppfs_port_decode.v ----
`timescale 1ns/1ns
`include "ppfs_defs.vh"
module ppfs_port_decode #(
	parameter [7:0] OUT_MASK   = 8'hFF,
	parameter [7:0] OTHER_MASK = 8'hFF
) (
	input  wire [15:0] sel,
	input  wire [7:0]  portData,
	input  wire [7:0]  altOut,
	input  wire [7:0]  altOutEn,
	output reg  [7:0]  pinOut,
	output reg  [7:0]  pinOutEn,
	output reg  [7:0]  pullUpEn,
	output reg  [7:0]  altSelect,
	output reg  [7:0]  inputMode
);
	integer n;
	reg [1:0] code;

	always @* begin
		pinOut    = 8'h00;
		pinOutEn  = 8'h00;
		pullUpEn  = 8'h00;
		altSelect = 8'h00;
		inputMode = 8'h00;
		code      = 2'b00;
		for (n = 0; n < 8; n = n + 1) begin
			code = sel[2*n +: 2];
			case (code)
			`PPFS_CODE_OTHER: begin
				// reserved pins stay undriven
				if (OTHER_MASK[n]) begin
					altSelect[n] = 1'b1;
					pinOut[n]    = altOut[n];
					pinOutEn[n]  = altOutEn[n];
				end
			end
			`PPFS_CODE_OUT: begin
				if (OUT_MASK[n]) begin
					pinOut[n]   = portData[n];
					pinOutEn[n] = 1'b1;
				end
			end
			`PPFS_CODE_IN_PU: begin
				inputMode[n] = 1'b1;
				pullUpEn[n]  = 1'b1;
			end
			`PPFS_CODE_IN_NOPU: begin
				inputMode[n] = 1'b1;
			end
			default: begin
				inputMode[n] = 1'b0;
			end
			endcase
		end
	end
endmodule

// ---- verilog/ppfs_sync2.v ----
`timescale 1ns/1ns
module ppfs_sync2 #(
	parameter WIDTH = 8
) (
	input  wire             ref_clk,
	input  wire [WIDTH-1:0] async,
	output wire [WIDTH-1:0] synced
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	// no reset: levels only, settled after two edges
	always @(posedge ref_clk) begin
		meta_q <= async;
		sync_q <= meta_q;
	end

	assign synced = sync_q;
endmodule
